// ==== msc_pkg.sv ====
package msc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map: printed offsets are indexes, byte address is four times that
	localparam logic [31:0] MSC_MODE_STATUS_IDX    = 32'h000EE011;
	localparam logic [31:0] MSC_SYSTEM_CONTROL_IDX = 32'h000EE012;
	localparam logic [31:0] MSC_MODE_STATUS_ADDR   = {MSC_MODE_STATUS_IDX[29:0], 2'h0};
	localparam logic [31:0] MSC_SYSTEM_CONTROL_ADDR = {MSC_SYSTEM_CONTROL_IDX[29:0], 2'h0};

	////////////////////////////////////////////////////////////////////////////////
	// Mode status layout
	localparam logic [7:0]  MSC_MODE_STATUS_FIXED  = 8'hC0;
	localparam int          MSC_MS_SENSE_HI        = 2;
	localparam int          MSC_MS_SENSE_LO        = 0;

	////////////////////////////////////////////////////////////////////////////////
	// System control layout and value after reset
	localparam logic [7:0]  MSC_SYSTEM_CONTROL_RESET = 8'h09;
	localparam int          MSC_SC_STANDBY_BIT     = 7;
	localparam int          MSC_SC_SETTLE_HI       = 6;
	localparam int          MSC_SC_SETTLE_LO       = 4;
	localparam int          MSC_SC_USER_FLAG_BIT   = 3;
	localparam int          MSC_SC_NMI_EDGE_BIT    = 2;
	localparam int          MSC_SC_BUS_HOLD_BIT    = 1;
	localparam int          MSC_SC_RAM_BIT         = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Settle wait selection
	localparam int          MSC_SETTLE_WIDTH       = 19;
	localparam logic [2:0]  MSC_SETTLE_CODE_MAX    = 3'h5;
	localparam logic [2:0]  MSC_SETTLE_CODE_SHORT  = 3'h6;
	localparam logic [18:0] MSC_SETTLE_SHORT_CYCLES = 19'h00400;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite responses
	localparam logic [1:0]  MSC_RESP_OKAY          = 2'h0;
	localparam logic [1:0]  MSC_RESP_DECERR        = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		MSC_SPACE_NONE = 2'h0,
		MSC_SPACE_64K  = 2'h1,
		MSC_SPACE_1M   = 2'h2,
		MSC_SPACE_16M  = 2'h3
	} msc_space_t;

	typedef enum logic [1:0] {
		MSC_WIDTH_NONE = 2'h0,
		MSC_WIDTH_8    = 2'h1,
		MSC_WIDTH_16   = 2'h2
	} msc_width_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] number;
		msc_space_t space;
		msc_width_t init_width;
		logic       expanded;
		logic       rom_enable;
	} msc_mode_t;

	typedef enum logic [3:0] {
		MSC_ST_RUN     = 4'h1,
		MSC_ST_SLEEP   = 4'h2,
		MSC_ST_STANDBY = 4'h4,
		MSC_ST_SETTLE  = 4'h8
	} msc_state_t;

endpackage

// ==== msc_mode_decode.sv ====
`timescale 1ns/100ps
module msc_mode_decode (
	input  wire logic [2:0]        mode_code,
	output msc_pkg::msc_mode_t     mode
);
	import msc_pkg::*;

	always_comb begin
		mode = '0;
		mode.number = mode_code;
		case (mode_code)
			3'h1: begin
				mode = '{1'b1, mode_code, MSC_SPACE_1M, MSC_WIDTH_8, 1'b1, 1'b0};
			end
			3'h2: begin
				mode = '{1'b1, mode_code, MSC_SPACE_1M, MSC_WIDTH_16, 1'b1, 1'b0};
			end
			3'h3: begin
				mode = '{1'b1, mode_code, MSC_SPACE_16M, MSC_WIDTH_8, 1'b1, 1'b0};
			end
			3'h4: begin
				mode = '{1'b1, mode_code, MSC_SPACE_16M, MSC_WIDTH_16, 1'b1, 1'b0};
			end
			3'h5: begin
				mode = '{1'b1, mode_code, MSC_SPACE_16M, MSC_WIDTH_8, 1'b1, 1'b1};
			end
			3'h6: begin
				mode = '{1'b1, mode_code, MSC_SPACE_64K, MSC_WIDTH_NONE, 1'b0, 1'b1};
			end
			3'h7: begin
				mode = '{1'b1, mode_code, MSC_SPACE_1M, MSC_WIDTH_NONE, 1'b0, 1'b1};
			end
			default: begin
				// Prohibited strap: nothing enabled, flagged as invalid
				mode = '{1'b0, mode_code, MSC_SPACE_NONE, MSC_WIDTH_NONE, 1'b0, 1'b0};
			end
		endcase
	end

endmodule

// ==== msc_top.sv ====
// Behaviour
// RULE1: Decode three mode pins into modes 1-7
// RULE2: Initial bus width follows the selected mode
// RULE3: ROM off modes 1-4, on 5-7
// RULE4: Address space size follows the mode
// RULE5: Bus is 8-bit only if all areas 8-bit
// RULE6: RAM disabled maps its range externally
// RULE7: Mode pins change only during reset
// RULE8: Mode pins never strapped to all zero
// RULE9: Mode status top bits 11, next 000
// RULE10: Mode status low bits show live pins
// RULE11: Boot mode inverts top mode sense bit
// RULE12: Standby select picks sleep or standby
// RULE13: Standby select stays set after wake
// RULE14: Settle field picks standby exit wait
// RULE15: Software sets settle wait of 7 ms
// RULE16: User flag enable picks flag role
// RULE17: Edge select picks nonmaskable request edge
// RULE18: Bus hold picks float or hold in standby
// RULE19: RAM enable set by reset, kept in standby
// RULE20: Exception entry sets mask, maybe user flag
// RULE21: Mode status writes ignored, fixed bits fixed
`timescale 1ns/100ps
module msc_top #(
	parameter int SETTLE_BASE = 8192
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              mode_pin_high,
	input  wire logic              mode_pin_mid,
	input  wire logic              mode_pin_low,
	input  wire logic              boot_mode_pin,
	input  wire logic              nmi_pin,
	input  wire logic              halt_req,
	input  wire logic              ext_irq_wake,
	input  wire logic              exception_entry,
	input  wire logic              area_all_8bit,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output msc_pkg::msc_mode_t     op_mode,
	output logic                   mode_prohibited,
	output logic                   ext_bus_16bit,
	output logic                   onchip_ram_enable,
	output logic                   ram_range_external,
	output msc_pkg::msc_state_t    power_state,
	output logic                   nmi_request,
	output logic                   user_flag_is_mask,
	output logic                   set_mask_flag,
	output logic                   set_user_flag,
	output logic                   bus_drive_oe_n,
	output logic                   ctrl_force_high
);
	import msc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release synchroniser
	logic              rst_meta_n;
	logic              rst_sync_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second
	// Nmi stages reset to the idle high level: no false edge
	logic [4:0]        pin_meta;
	logic [4:0]        pin_sync;
	logic              nmi_prev;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_meta <= 5'h08;
			pin_sync <= 5'h08;
			nmi_prev <= 1'b1;
		end else begin
			pin_meta <= {boot_mode_pin, nmi_pin, mode_pin_high, mode_pin_mid, mode_pin_low};
			pin_sync <= pin_meta;
			nmi_prev <= pin_sync[3];
		end
	end

	wire logic [2:0]   mode_code = pin_sync[2:0];
	wire logic         nmi_level = pin_sync[3];
	wire logic         boot_mode = pin_sync[4];

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode
	msc_mode_t         mode_dec;

	msc_mode_decode u_decode (
		.mode_code (mode_code),
		.mode      (mode_dec)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register file
	logic [7:0]        system_control;

	wire logic         standby_select   = system_control[MSC_SC_STANDBY_BIT];
	wire logic [2:0]   settle_wait_select = system_control[MSC_SC_SETTLE_HI:MSC_SC_SETTLE_LO];
	wire logic         user_flag_enable = system_control[MSC_SC_USER_FLAG_BIT];
	wire logic         nonmaskable_edge_select = system_control[MSC_SC_NMI_EDGE_BIT];
	wire logic         standby_bus_hold = system_control[MSC_SC_BUS_HOLD_BIT];
	wire logic         onchip_memory_enable = system_control[MSC_SC_RAM_BIT];

	// Live pins at read time; boot mode flips the top sense bit
	wire logic [2:0]   mode_sense_bits = {mode_code[2] ^ boot_mode, mode_code[1:0]}; // see RULE10 RULE11
	wire logic [7:0]   mode_status = MSC_MODE_STATUS_FIXED | {5'h00, mode_sense_bits}; // see RULE9

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	logic              aw_pend;
	logic              w_pend;
	logic [31:0]       aw_addr_q;
	logic [7:0]        w_data_q;
	logic              w_strb_q;

	wire logic         aw_fire = s_axi_awvalid && s_axi_awready;
	wire logic         w_fire  = s_axi_wvalid && s_axi_wready;
	wire logic         wr_go   = aw_pend && w_pend && !s_axi_bvalid;
	wire logic         wr_hit_sc = aw_addr_q == MSC_SYSTEM_CONTROL_ADDR;
	wire logic         wr_hit_ms = aw_addr_q == MSC_MODE_STATUS_ADDR;
	wire logic         wr_sc_en = wr_go && wr_hit_sc && w_strb_q;
	wire logic [1:0]   wr_resp = (wr_hit_sc || wr_hit_ms) ? MSC_RESP_OKAY : MSC_RESP_DECERR;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= MSC_RESP_OKAY;
			aw_pend       <= 1'b0;
			w_pend        <= 1'b0;
			aw_addr_q     <= 32'h00000000;
			w_data_q      <= 8'h00;
			w_strb_q      <= 1'b0;
		end else begin
			if (aw_fire) begin
				s_axi_awready <= 1'b0;
				aw_pend       <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
			end else if (!aw_pend && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (w_fire) begin
				s_axi_wready <= 1'b0;
				w_pend       <= 1'b1;
				w_data_q     <= s_axi_wdata[7:0];
				w_strb_q     <= s_axi_wstrb[0];
			end else if (!w_pend && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_go) begin
				// Writes to mode status are answered but change nothing
				s_axi_bvalid <= 1'b1; // see RULE21
				s_axi_bresp  <= wr_resp;
				aw_pend      <= 1'b0;
				w_pend       <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	wire logic         ar_fire = s_axi_arvalid && s_axi_arready;
	wire logic         rd_hit_sc = s_axi_araddr == MSC_SYSTEM_CONTROL_ADDR;
	wire logic         rd_hit_ms = s_axi_araddr == MSC_MODE_STATUS_ADDR;
	wire logic [7:0]   rd_byte = rd_hit_ms ? mode_status : (rd_hit_sc ? system_control : 8'h00);
	wire logic [1:0]   rd_resp = (rd_hit_sc || rd_hit_ms) ? MSC_RESP_OKAY : MSC_RESP_DECERR;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= MSC_RESP_OKAY;
		end else begin
			if (ar_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h000000, rd_byte}; // see RULE10
				s_axi_rresp   <= rd_resp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// System control register
	// Only reset or a software write changes the standby select bit, so a wake leaves it set
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			system_control <= MSC_SYSTEM_CONTROL_RESET; // see RULE12 RULE16 RULE17 RULE19
		end else if (wr_sc_en) begin
			system_control <= w_data_q; // see RULE13
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Nonmaskable request edge
	wire logic         nmi_rise = nmi_level && !nmi_prev;
	wire logic         nmi_fall = !nmi_level && nmi_prev;
	wire logic         nmi_edge = nonmaskable_edge_select ? nmi_rise : nmi_fall; // see RULE17

	////////////////////////////////////////////////////////////////////////////////
	// Power state sequencer
	msc_state_t        state;
	msc_state_t        next_state;
	logic [18:0]       settle_count;

	// Illegal settle code 111 falls back to the longest wait, the safe side
	wire logic [2:0]   settle_code = (settle_wait_select > MSC_SETTLE_CODE_SHORT) ?
	                                 MSC_SETTLE_CODE_MAX : settle_wait_select;
	wire logic [18:0]  settle_long = 19'(SETTLE_BASE << settle_code);
	wire logic [18:0]  settle_load = (settle_code == MSC_SETTLE_CODE_SHORT) ?
	                                 MSC_SETTLE_SHORT_CYCLES : settle_long; // see RULE14
	wire logic         wake = ext_irq_wake || nmi_edge;
	wire logic         settle_done = settle_count <= 19'h00001;

	always_comb begin
		next_state = state;
		case (state)
			MSC_ST_RUN: begin
				if (halt_req) begin
					next_state = standby_select ? MSC_ST_STANDBY : MSC_ST_SLEEP; // see RULE12
				end
			end
			MSC_ST_SLEEP: begin
				if (wake) begin
					next_state = MSC_ST_RUN;
				end
			end
			MSC_ST_STANDBY: begin
				if (wake) begin
					next_state = MSC_ST_SETTLE; // see RULE14
				end
			end
			MSC_ST_SETTLE: begin
				if (settle_done) begin
					next_state = MSC_ST_RUN;
				end
			end
			default: begin
				next_state = MSC_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state        <= MSC_ST_RUN;
			settle_count <= 19'h00000;
		end else begin
			state <= next_state;
			if (state == MSC_ST_STANDBY && wake) begin
				settle_count <= settle_load; // see RULE14
			end else if (state == MSC_ST_SETTLE && !settle_done) begin
				settle_count <= settle_count - 19'h00001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode derived outputs and standby pin control
	wire logic         bus_16 = mode_dec.expanded && !area_all_8bit; // see RULE5
	wire logic         ram_ext = mode_dec.expanded && !onchip_memory_enable; // see RULE6
	wire logic         in_standby = next_state == MSC_ST_STANDBY;
	// Float when hold is off; otherwise address held and controls high
	wire logic         next_float = in_standby && !standby_bus_hold; // see RULE18
	wire logic         next_ctrl_high = in_standby && standby_bus_hold; // see RULE18

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			op_mode            <= '0;
			mode_prohibited    <= 1'b0;
			ext_bus_16bit      <= 1'b0;
			onchip_ram_enable  <= 1'b1;
			ram_range_external <= 1'b0;
			power_state        <= MSC_ST_RUN;
			bus_drive_oe_n     <= 1'b0;
			ctrl_force_high    <= 1'b0;
		end else begin
			op_mode            <= mode_dec; // see RULE1 RULE2 RULE3 RULE4
			mode_prohibited    <= !mode_dec.valid; // see RULE1
			ext_bus_16bit      <= bus_16;
			onchip_ram_enable  <= onchip_memory_enable; // see RULE19
			ram_range_external <= ram_ext;
			power_state        <= next_state;
			bus_drive_oe_n     <= next_float;
			ctrl_force_high    <= next_ctrl_high;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt side effects
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			nmi_request       <= 1'b0;
			user_flag_is_mask <= 1'b0;
			set_mask_flag     <= 1'b0;
			set_user_flag     <= 1'b0;
		end else begin
			nmi_request       <= nmi_edge; // see RULE17
			user_flag_is_mask <= !user_flag_enable; // see RULE16
			set_mask_flag     <= exception_entry; // see RULE20
			set_user_flag     <= exception_entry && !user_flag_enable; // see RULE20
		end
	end

endmodule

// ==== msc_strap_model.sv ====
`timescale 1ns/100ps
module msc_strap_model (
	input  wire logic       rst_n,
	input  wire logic [2:0] strap_code,
	output logic            mode_pin_high,
	output logic            mode_pin_mid,
	output logic            mode_pin_low
);
	////////////////////////////////////////////////////////////////////////////////
	// Board straps: moved only under reset, and never to the all-zero code
	always_latch begin
		if (!rst_n && strap_code != 3'h0) begin
			{mode_pin_high, mode_pin_mid, mode_pin_low} <= strap_code;
		end
	end
endmodule

// ==== msc_top_asserts.sv ====
`timescale 1ns/100ps
module msc_asserts (
	input wire logic                core_clk,
	input wire logic                rst_n,
	input wire logic                mode_pin_high,
	input wire logic                mode_pin_mid,
	input wire logic                mode_pin_low,
	input wire logic                boot_mode_pin,
	input wire logic                halt_req,
	input wire logic                exception_entry,
	input wire logic                area_all_8bit,
	input wire logic [31:0]         s_axi_araddr,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic [1:0]          s_axi_rresp,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire msc_pkg::msc_mode_t  op_mode,
	input wire logic                ext_bus_16bit,
	input wire logic                onchip_ram_enable,
	input wire logic                ram_range_external,
	input wire msc_pkg::msc_state_t power_state,
	input wire logic                set_mask_flag,
	input wire logic                set_user_flag,
	input wire logic                user_flag_is_mask,
	input wire logic                bus_drive_oe_n,
	input wire logic                ctrl_force_high
);
	import msc_pkg::*;

	logic [31:0] rd_addr;
	logic [2:0]  rd_sense;

	// Pins only move under reset, so the level at the read handshake is the answer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_addr <= 32'h0;
			rd_sense <= 3'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_addr <= s_axi_araddr;
			rd_sense <= {mode_pin_high ^ boot_mode_pin, mode_pin_mid, mode_pin_low};
		end
	end

	wire is_status_rd = s_axi_rvalid && rd_addr == MSC_MODE_STATUS_ADDR;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	status_fixed_a: assert property (is_status_rd |-> s_axi_rdata[31:3] == {24'h0, 5'h18}
		&& s_axi_rresp == MSC_RESP_OKAY) else $error("mode status fixed bits wrong");
	status_sense_a: assert property (is_status_rd |-> s_axi_rdata[2:0] == rd_sense)
		else $error("mode status sense bits wrong");
	mode_number_a: assert property (op_mode.valid
		|-> op_mode.number == {mode_pin_high, mode_pin_mid, mode_pin_low}) else $error("mode number");
	mode_attr_a: assert property (op_mode.valid |-> op_mode.rom_enable == (op_mode.number > 3'h4)
		&& op_mode.expanded == (op_mode.number < 3'h6)) else $error("rom or expansion wrong");
	bus_width_a: assert property (op_mode.valid && $past(op_mode.valid) && $stable(area_all_8bit)
		|-> ext_bus_16bit == (op_mode.expanded && !area_all_8bit)) else $error("bus width wrong");
	halt_state_a: assert property (halt_req && power_state == MSC_ST_RUN
		|=> power_state inside {MSC_ST_SLEEP, MSC_ST_STANDBY}) else $error("halt ignored");
	exc_flags_a: assert property (exception_entry
		|=> set_mask_flag && set_user_flag == user_flag_is_mask) else $error("entry flags wrong");
	run_bus_a: assert property (power_state == MSC_ST_RUN
		|-> !bus_drive_oe_n && !ctrl_force_high) else $error("bus not driven in run");
	stby_bus_a: assert property (power_state == MSC_ST_STANDBY
		|-> bus_drive_oe_n != ctrl_force_high) else $error("standby bus state wrong");
	ram_map_a: assert property (($stable(onchip_ram_enable) && $stable(op_mode))[*2]
		|-> ram_range_external == (op_mode.expanded && !onchip_ram_enable)) else $error("ram map");
	ram_reset_a: assert property ($rose(rst_n) |-> onchip_ram_enable)
		else $error("ram enable not set by reset");

	cover property (power_state == MSC_ST_SETTLE ##1 power_state == MSC_ST_RUN);
	cover property (is_status_rd && s_axi_rready);
	cover property (set_user_flag);
endmodule

bind msc_top msc_asserts i_msc_asserts (.core_clk, .rst_n, .mode_pin_high, .mode_pin_mid,
	.mode_pin_low, .boot_mode_pin, .halt_req, .exception_entry, .area_all_8bit, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.op_mode, .ext_bus_16bit, .onchip_ram_enable, .ram_range_external, .power_state,
	.set_mask_flag, .set_user_flag, .user_flag_is_mask, .bus_drive_oe_n, .ctrl_force_high);

// ==== mode_select_system_control_test.sv ====
`timescale 1ns/100ps
module mode_select_system_control_test;
	import msc_pkg::*;

	localparam int SETTLE_BASE = 8;
	localparam logic [31:0] SC = MSC_SYSTEM_CONTROL_ADDR;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  strap_code = 3'h1;
	logic        mode_pin_high, mode_pin_mid, mode_pin_low;
	logic        boot_mode_pin = 1'b0, nmi_pin = 1'b1, area_all_8bit = 1'b0;
	logic        halt_req = 1'b0, ext_irq_wake = 1'b0, exception_entry = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	msc_mode_t   op_mode;
	msc_state_t  power_state;
	logic        mode_prohibited, ext_bus_16bit, onchip_ram_enable, ram_range_external;
	logic        nmi_request, user_flag_is_mask, set_mask_flag, set_user_flag;
	logic        bus_drive_oe_n, ctrl_force_high;
	logic [31:0] rd;
	int          failures = 0, n_compared = 0;
	msc_space_t  exp_space [1:7] = '{MSC_SPACE_1M, MSC_SPACE_1M, MSC_SPACE_16M, MSC_SPACE_16M,
		MSC_SPACE_16M, MSC_SPACE_64K, MSC_SPACE_1M};
	msc_width_t  exp_width [1:7] = '{MSC_WIDTH_8, MSC_WIDTH_16, MSC_WIDTH_8, MSC_WIDTH_16,
		MSC_WIDTH_8, MSC_WIDTH_NONE, MSC_WIDTH_NONE};

	always #2.5 core_clk = ~core_clk;

	msc_strap_model i_straps (.rst_n, .strap_code, .mode_pin_high, .mode_pin_mid, .mode_pin_low);

	msc_top #(.SETTLE_BASE(SETTLE_BASE)) i_dut (.core_clk, .rst_n, .mode_pin_high, .mode_pin_mid,
		.mode_pin_low, .boot_mode_pin, .nmi_pin, .halt_req, .ext_irq_wake, .exception_entry,
		.area_all_8bit, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.op_mode, .mode_prohibited, .ext_bus_16bit, .onchip_ram_enable, .ram_range_external,
		.power_state, .nmi_request, .user_flag_is_mask, .set_mask_flag, .set_user_flag,
		.bus_drive_oe_n, .ctrl_force_high);

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("compared %0d, mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic do_reset(input logic [2:0] code, input logic boot);
		@(posedge core_clk);
		rst_n <= 1'b0;
		strap_code <= code;
		boot_mode_pin <= boot;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
	endtask

	// Bready is offered with the request; the slave may take address and data apart
	task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] st);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		#1;
	endtask

	task automatic axi_rd(input logic [31:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		#1;
	endtask

	// Bits: halt, wake, exception entry
	task automatic pulse(input logic [2:0] v);
		@(posedge core_clk);
		{halt_req, ext_irq_wake, exception_entry} <= v;
		@(posedge core_clk);
		{halt_req, ext_irq_wake, exception_entry} <= 3'h0;
		#1;
	endtask

	task automatic nmi_try(input logic lvl, input int exp_n);
		int seen = 0;
		@(posedge core_clk);
		nmi_pin <= lvl;
		repeat (8) begin
			@(posedge core_clk);
			#1;
			if (nmi_request !== 1'b0) seen++;
		end
		chk(seen, exp_n, "nmi requests");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_modes;
		for (int c = 1; c < 8; c++) begin
			do_reset(c[2:0], c == 5);
			chk(op_mode.number, c, "mode number");
			chk({mode_prohibited, op_mode.valid}, 2'b01, "legal mode");
			chk(op_mode.init_width, exp_width[c], "initial width");
			chk({op_mode.expanded, op_mode.rom_enable}, {c < 6, c > 4}, "rom use");
			chk(op_mode.space, exp_space[c], "space");
			axi_wr(MSC_MODE_STATUS_ADDR, 8'h3F, 4'hF);
			chk(rsp, MSC_RESP_OKAY, "status write");
			axi_rd(MSC_MODE_STATUS_ADDR);
			chk(rd, {24'h0, 5'h18, c[2] ^ (c == 5), c[1:0]}, "status");
			@(posedge core_clk);
			area_all_8bit <= 1'b1;
			repeat (4) @(posedge core_clk);
			chk(ext_bus_16bit, 1'b0, "bus with all areas 8-bit");
			area_all_8bit <= 1'b0;
			repeat (4) @(posedge core_clk);
			chk(ext_bus_16bit, c < 6, "bus with a 16-bit area");
		end
		$display("modes test done");
	endtask

	task automatic t_regs;
		do_reset(3'h1, 1'b0);
		axi_rd(SC);
		chk(rd, 32'h09, "control after reset");
		chk({user_flag_is_mask, onchip_ram_enable, ram_range_external}, 3'b010, "outs");
		axi_wr(SC, 8'h62, 4'h1);
		axi_rd(SC);
		chk(rd, 32'h62, "control written");
		chk({user_flag_is_mask, onchip_ram_enable, ram_range_external}, 3'b101, "outs");
		axi_wr(SC, 8'h09, 4'hE);
		axi_rd(SC);
		chk(rd, 32'h62, "write without byte 0");
		axi_wr(32'h0000_1000, 8'h09, 4'hF);
		chk(rsp, MSC_RESP_DECERR, "unmapped write");
		axi_rd(32'h0000_1000);
		chk(rsp, MSC_RESP_DECERR, "unmapped read");
		do_reset(3'h1, 1'b0);
		chk(onchip_ram_enable, 1'b1, "ram enable after reset");
		$display("register test done");
	endtask

	task automatic t_power;
		logic [7:0] sc;
		int n;
		pulse(3'h4);
		chk(power_state, MSC_ST_SLEEP, "halt to sleep");
		pulse(3'h2);
		chk(power_state, MSC_ST_RUN, "sleep wake");
		for (int c = 0; c < 8; c++) begin
			sc = {1'b1, c[2:0], 2'b10, c[0], 1'b1};
			axi_wr(SC, sc, 4'h1);
			pulse(3'h4);
			chk(power_state, MSC_ST_STANDBY, "halt to standby");
			chk({bus_drive_oe_n, ctrl_force_high}, {~c[0], c[0]}, "standby bus");
			pulse(3'h2);
			n = 0;
			while (power_state === MSC_ST_SETTLE && n < 2000) begin
				@(posedge core_clk);
				#1;
				n++;
			end
			chk(n, c == 6 ? 1024 : SETTLE_BASE << (c > 5 ? 5 : c), "settle");
			axi_rd(SC);
			chk(rd, {24'h0, sc}, "control kept over standby");
		end
		$display("power test done");
	endtask

	task automatic t_events;
		axi_wr(SC, 8'h09, 4'h1);
		nmi_try(1'b0, 1);
		nmi_try(1'b1, 0);
		axi_wr(SC, 8'h0D, 4'h1);
		nmi_try(1'b0, 0);
		nmi_try(1'b1, 1);
		pulse(3'h1);
		chk({set_mask_flag, set_user_flag}, 2'b10, "entry with user bit");
		axi_wr(SC, 8'h01, 4'h1);
		pulse(3'h1);
		chk({set_mask_flag, set_user_flag}, 2'b11, "entry with mask bit");
		$display("event test done");
	endtask

	initial begin
		do_reset(3'h1, 1'b0);
		t_modes();
		t_regs();
		t_power();
		t_events();
		give_verdict();
	end

	// The whole run needs some 2200 cycles; far beyond that means a hang
	initial begin
		#200000;
		failures++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule
